/* File: verilog/adc_ctrl_pkg.sv */
// Constants, field layout and state encodings of the serial converter control
package adc_ctrl_pkg;
  localparam int CTRL_W = 8;
  localparam int RESULT_W = 8;
  localparam int CTRL_START = 7;
  localparam int CTRL_SEL_HI = 6;
  localparam int CTRL_SEL_LO = 4;
  localparam int CTRL_POLARITY = 3;
  localparam int CTRL_INPUT_CFG = 2;
  localparam int CTRL_KEEP = 1;
  localparam int CTRL_CLKSRC = 0;
  localparam logic [2:0] LAST_CTRL_BIT = 3'h7;
  localparam logic [3:0] PH_IDLE = 4'h0;
  localparam logic [3:0] PH_STRB1 = 4'h1;
  localparam logic [3:0] PH_MSB = 4'h2;
  localparam logic [3:0] PH_LSB = 4'h9;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 25000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_LOAD = 8'(CONV_CYCLES - 1);

  typedef enum logic [2:0] {
    F_IDLE = 3'b001,
    F_CTRL = 3'b010,
    F_CONV = 3'b100
  } frame_state_t;
endpackage : adc_ctrl_pkg

/* File: verilog/adc_sync_bits.sv */
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module adc_sync_bits #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage;

  // No reset: a synchroniser only follows its input
  always_ff @(posedge clk)
  begin
    stage <= d;
    q <= stage;
  end
endmodule : adc_sync_bits

/* File: verilog/adc_toggle_event.sv */
// Toggle-to-pulse event crossing into the receiving clock domain
`timescale 1ns/10ps
module adc_toggle_event (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event
  input wire logic toggle_in,
  output logic pulse
);
  logic stage1;
  logic stage2;
  logic seen;
  logic next_seen;

  always_ff @(posedge clk)
  begin
    stage1 <= toggle_in;
    stage2 <= stage1;
  end

  always_comb
  begin
    next_seen = stage2;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      seen <= 1'b0;
    else
      seen <= next_seen;
  end

  assign pulse = stage2 ^ seen;
endmodule : adc_toggle_event

/* File: verilog/adc_serial_conversion_control.sv */
// Serial framing, conversion pacing, result shifting and power control
`timescale 1ns/10ps
module adc_serial_conversion_control (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe_n,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_n,
  // Power pin and analog front end
  input wire logic hard_shutdown_n,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] analog_value,
  // Status and front-end configuration
  output logic powered_up,
  output logic conversion_active,
  output logic [2:0] channel_select,
  output logic polarity_select,
  output logic input_config_select
);
  // Link side, rising edges
  logic rst_link;
  logic hard_shutdown_n_link;
  logic new_frame;
  adc_ctrl_pkg::frame_state_t fstate, next_fstate, cur_state;
  logic [2:0] bitcnt, next_bitcnt;
  logic [6:0] shreg, next_shreg;
  logic [adc_ctrl_pkg::CTRL_W-1:0] ctrl_byte, next_ctrl_byte;
  logic ext_mode, next_ext_mode;
  logic start_tog, next_start_tog;
  logic conv_req_tog, next_conv_req_tog;
  logic fresh, next_fresh;
  logic done_ff1;
  // Link side, falling edges
  logic done_ff2;
  logic [adc_ctrl_pkg::RESULT_W-1:0] analog_link;
  logic req_ack, next_req_ack;
  logic done_ack, next_done_ack;
  logic [3:0] phase, next_phase;
  logic [7:0] oshift, next_oshift;
  logic dout_r, next_dout_r;
  logic strobe_ext, next_strobe_ext;
  logic msb_shown, next_msb_shown;
  logic ext_done_tog, next_ext_done_tog;
  logic abort_link;
  // System side
  logic hard_shutdown_n_clk;
  logic [adc_ctrl_pkg::RESULT_W-1:0] analog_clk;
  logic start_ev;
  logic ext_done_ev;
  logic keep, next_keep;
  logic powered, next_powered;
  logic converting, next_converting;
  logic [7:0] conv_cnt, next_conv_cnt;
  logic strobe_int, next_strobe_int;
  logic [7:0] sample, next_sample;
  logic [7:0] result_int, next_result_int;
  logic done_tog, next_done_tog;
  logic [4:0] cfg, next_cfg;

  adc_sync_bits #(.W(2)) u_sync_link (
    .clk(sclk),
    .d({rst, hard_shutdown_n}),
    .q({rst_link, hard_shutdown_n_link})
  );

  adc_sync_bits #(.W(adc_ctrl_pkg::RESULT_W)) u_sync_analog_link (
    .clk(sclk),
    .d(analog_value),
    .q(analog_link)
  );

  adc_sync_bits #(.W(1 + adc_ctrl_pkg::RESULT_W)) u_sync_sys (
    .clk(clk),
    .d({hard_shutdown_n, analog_value}),
    .q({hard_shutdown_n_clk, analog_clk})
  );

  adc_toggle_event u_start_ev (
    .clk(clk),
    .rst(rst),
    .toggle_in(start_tog),
    .pulse(start_ev)
  );

  adc_toggle_event u_ext_done_ev (
    .clk(clk),
    .rst(rst),
    .toggle_in(ext_done_tog),
    .pulse(ext_done_ev)
  );

  // Select high marks a frame boundary; set by select itself since the clock may stop, cleared on the first rising edge
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      new_frame <= 1'b1;
    else
      new_frame <= 1'b0;
  end

  assign cur_state = new_frame ? adc_ctrl_pkg::F_IDLE : fstate;

  // Framing of the control byte on rising edges
  always_comb
  begin
    next_fstate = cur_state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ctrl_byte = ctrl_byte;
    next_ext_mode = ext_mode;
    next_start_tog = start_tog;
    next_conv_req_tog = conv_req_tog;
    // First rising edge of a new frame; the falling side drops a stale serial-paced stream on it
    next_fresh = new_frame;
    if (cs_n)
      next_fstate = fstate;
    else if (!hard_shutdown_n_link)
      next_fstate = adc_ctrl_pkg::F_IDLE;
    else
      case (cur_state)
        adc_ctrl_pkg::F_IDLE:
          if (din)
          begin
            next_fstate = adc_ctrl_pkg::F_CTRL;
            next_bitcnt = 3'h1;
            next_shreg = 7'h01;
          end
        adc_ctrl_pkg::F_CTRL:
        begin
          next_shreg = {shreg[5:0], din};
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == adc_ctrl_pkg::LAST_CTRL_BIT)
          begin
            next_ctrl_byte = {shreg, din};
            next_ext_mode = din;
            next_start_tog = ~start_tog;
            next_conv_req_tog = ~conv_req_tog;
            next_fstate = adc_ctrl_pkg::F_CONV;
          end
        end
        adc_ctrl_pkg::F_CONV:
          if (din && msb_shown)
          begin
            next_fstate = adc_ctrl_pkg::F_CTRL;
            next_bitcnt = 3'h1;
            next_shreg = 7'h01;
          end
        default:
          next_fstate = adc_ctrl_pkg::F_IDLE;
      endcase
  end

  always_ff @(posedge sclk)
  begin
    done_ff1 <= done_tog;
    if (rst_link)
    begin
      fstate <= adc_ctrl_pkg::F_IDLE;
      bitcnt <= 3'h0;
      shreg <= 7'h00;
      ctrl_byte <= 8'h00;
      ext_mode <= 1'b0;
      start_tog <= 1'b0;
      conv_req_tog <= 1'b0;
      fresh <= 1'b0;
    end
    else
    begin
      fstate <= next_fstate;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ctrl_byte <= next_ctrl_byte;
      ext_mode <= next_ext_mode;
      start_tog <= next_start_tog;
      conv_req_tog <= next_conv_req_tog;
      fresh <= next_fresh;
    end
  end

  // Result shifting on falling edges; the falling-edge second stage gives the MSB on edge two
  assign abort_link = ext_mode && (fstate == adc_ctrl_pkg::F_IDLE || fresh || !hard_shutdown_n_link);

  always_comb
  begin
    next_req_ack = req_ack;
    next_done_ack = done_ack;
    next_phase = phase;
    next_oshift = {oshift[6:0], 1'b0};
    next_dout_r = oshift[7];
    next_strobe_ext = strobe_ext;
    next_msb_shown = msb_shown;
    next_ext_done_tog = ext_done_tog;
    if (abort_link)
    begin
      next_phase = adc_ctrl_pkg::PH_IDLE;
      next_strobe_ext = 1'b0;
      next_oshift = 8'h00;
      next_dout_r = 1'b0;
    end
    else if (conv_req_tog != req_ack)
    begin
      next_req_ack = conv_req_tog;
      next_msb_shown = 1'b0;
      next_dout_r = 1'b0;
      next_oshift = 8'h00;
      if (ext_mode)
      begin
        next_strobe_ext = 1'b1;
        next_phase = adc_ctrl_pkg::PH_STRB1;
        next_oshift = analog_link;
      end
    end
    else if (phase == adc_ctrl_pkg::PH_STRB1)
    begin
      next_phase = adc_ctrl_pkg::PH_MSB;
      next_oshift = oshift;
      next_dout_r = 1'b0;
    end
    else if (phase != adc_ctrl_pkg::PH_IDLE)
    begin
      if (phase == adc_ctrl_pkg::PH_MSB)
      begin
        next_strobe_ext = 1'b0;
        next_msb_shown = 1'b1;
      end
      if (phase == adc_ctrl_pkg::PH_LSB)
      begin
        next_phase = adc_ctrl_pkg::PH_IDLE;
        next_ext_done_tog = ~ext_done_tog;
      end
      else
        next_phase = phase + 4'h1;
    end
    else if (!ext_mode && done_ff2 != done_ack)
    begin
      next_done_ack = done_ff2;
      next_dout_r = result_int[7];
      next_oshift = {result_int[6:0], 1'b0};
      next_msb_shown = 1'b1;
    end
  end

  always_ff @(negedge sclk)
  begin
    done_ff2 <= done_ff1;
    if (rst_link)
    begin
      req_ack <= 1'b0;
      done_ack <= 1'b0;
      phase <= adc_ctrl_pkg::PH_IDLE;
      oshift <= 8'h00;
      dout_r <= 1'b0;
      strobe_ext <= 1'b0;
      msb_shown <= 1'b0;
      ext_done_tog <= 1'b0;
    end
    else
    begin
      req_ack <= next_req_ack;
      done_ack <= next_done_ack;
      phase <= next_phase;
      oshift <= next_oshift;
      dout_r <= next_dout_r;
      strobe_ext <= next_strobe_ext;
      msb_shown <= next_msb_shown;
      ext_done_tog <= next_ext_done_tog;
    end
  end

  // Internal pacing and power state on the system clock
  always_comb
  begin
    next_keep = keep;
    next_powered = powered;
    next_converting = converting;
    next_conv_cnt = conv_cnt;
    next_strobe_int = strobe_int;
    next_sample = sample;
    next_result_int = result_int;
    next_done_tog = done_tog;
    next_cfg = cfg;
    if (converting)
    begin
      next_conv_cnt = conv_cnt - 8'h01;
      if (conv_cnt == 8'h00)
      begin
        next_converting = 1'b0;
        next_strobe_int = 1'b1;
        next_result_int = sample;
        next_done_tog = ~done_tog;
        if (!keep)
          next_powered = 1'b0;
      end
    end
    if (ext_done_ev && !keep)
      next_powered = 1'b0;
    // Control byte is stable well before its event crosses, so it is read directly
    if (start_ev)
    begin
      next_powered = 1'b1;
      next_keep = ctrl_byte[adc_ctrl_pkg::CTRL_KEEP];
      next_cfg = ctrl_byte[adc_ctrl_pkg::CTRL_SEL_HI:adc_ctrl_pkg::CTRL_INPUT_CFG];
      next_converting = !ctrl_byte[adc_ctrl_pkg::CTRL_CLKSRC];
      if (!ctrl_byte[adc_ctrl_pkg::CTRL_CLKSRC])
      begin
        next_conv_cnt = adc_ctrl_pkg::CONV_LOAD;
        next_strobe_int = 1'b0;
        next_sample = analog_clk;
      end
    end
    if (!hard_shutdown_n_clk)
    begin
      next_powered = 1'b0;
      next_converting = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      keep <= 1'b1;
      powered <= 1'b1;
      converting <= 1'b0;
      conv_cnt <= 8'h00;
      strobe_int <= 1'b1;
      sample <= 8'h00;
      result_int <= 8'h00;
      done_tog <= 1'b0;
      cfg <= 5'h00;
    end
    else
    begin
      keep <= next_keep;
      powered <= next_powered;
      converting <= next_converting;
      conv_cnt <= next_conv_cnt;
      strobe_int <= next_strobe_int;
      sample <= next_sample;
      result_int <= next_result_int;
      done_tog <= next_done_tog;
      cfg <= next_cfg;
    end
  end

  // Pin drive: strobe floats with select only under serial pacing
  assign dout_o = dout_r;
  assign dout_oe_n = cs_n;
  // A stale serial-paced strobe is hidden from select falling until the abort lands
  assign conversion_strobe_o = ext_mode ? (strobe_ext & ~(new_frame | fresh)) : strobe_int;
  assign conversion_strobe_oe_n = ext_mode & cs_n;
  assign powered_up = powered;
  assign conversion_active = converting;
  assign channel_select = cfg[4:2];
  assign polarity_select = cfg[1];
  assign input_config_select = cfg[0];

  property p_capture_hold;
    @(posedge sclk) disable iff (rst_link) cs_n |=> $stable(fstate);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("state moved with select high");

  property p_lead_zero;
    @(posedge sclk) disable iff (rst_link)
      (cur_state == adc_ctrl_pkg::F_IDLE && !cs_n && !din) |=> fstate == adc_ctrl_pkg::F_IDLE;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("leading zero left idle");

  property p_start_bit;
    @(posedge sclk) disable iff (rst_link)
      (cur_state == adc_ctrl_pkg::F_IDLE && !cs_n && din && hard_shutdown_n_link)
      |=> fstate == adc_ctrl_pkg::F_CTRL ##0 bitcnt == 3'h1;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not taken");

  property p_byte_req;
    @(posedge sclk) disable iff (rst_link)
      (fstate == adc_ctrl_pkg::F_CTRL && bitcnt == 3'h7 && !cs_n && !new_frame && hard_shutdown_n_link)
      |=> conv_req_tog != $past(conv_req_tog) && fstate == adc_ctrl_pkg::F_CONV;
  endproperty
  a_byte_req: assert property (p_byte_req) else $error("eighth bit gave no conversion");

  property p_strobe_two;
    @(negedge sclk) disable iff (rst_link || abort_link || conv_req_tog != req_ack)
      $rose(strobe_ext) |=> strobe_ext ##1 !strobe_ext && msb_shown;
  endproperty
  a_strobe_two: assert property (p_strobe_two) else $error("strobe not two clocks");

  property p_msb_follows;
    @(negedge sclk) disable iff (rst_link || abort_link)
      (ext_mode && phase == adc_ctrl_pkg::PH_MSB && conv_req_tog == req_ack)
      |=> dout_r == $past(oshift[7]) && !strobe_ext;
  endproperty
  a_msb_follows: assert property (p_msb_follows) else $error("MSB not after strobe");

  property p_zeros_after;
    @(negedge sclk) disable iff (rst_link)
      (phase == adc_ctrl_pkg::PH_IDLE && oshift == 8'h00 && conv_req_tog == req_ack
       && (ext_mode || done_ff2 == done_ack)) |=> !dout_r;
  endproperty
  a_zeros_after: assert property (p_zeros_after) else $error("nonzero after result");

  property p_int_done;
    @(posedge clk) disable iff (rst)
      (converting && conv_cnt == 8'h00 && hard_shutdown_n_clk && !start_ev)
      |=> strobe_int && !converting && done_tog != $past(done_tog);
  endproperty
  a_int_done: assert property (p_int_done) else $error("internal end not flagged");

  property p_power_up;
    @(posedge clk) disable iff (rst) (start_ev && hard_shutdown_n_clk) |=> powered;
  endproperty
  a_power_up: assert property (p_power_up) else $error("start did not power up");

  property p_shutdown;
    @(posedge clk) disable iff (rst) !hard_shutdown_n_clk |=> !powered && !converting;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown ignored");

  c_ext_conv: cover property (@(negedge sclk) disable iff (rst_link) $fell(strobe_ext));
  c_int_conv: cover property (@(posedge clk) disable iff (rst) $rose(strobe_int));
  c_overlap: cover property (@(posedge sclk) disable iff (rst_link)
    fstate == adc_ctrl_pkg::F_CONV && !cs_n && din && msb_shown);
endmodule : adc_serial_conversion_control

/* File: dv/adc_host_model.sv */
// Serial bus master model standing at the far side of the converter link
`timescale 1ns/10ps
module adc_host_model (
  // Link outputs
  output logic sclk,
  output logic cs_n,
  output logic din,
  // Link inputs
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic conversion_strobe_o
);
  logic last_dout;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    last_dout = 1'b0;
  end

  // Clocks with select high, so reset can cross into the link domain
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #7.5 sclk <= 1'b1;
      #7.5 sclk <= 1'b0;
    end
  endtask : idle_clocks

  task automatic select(input logic lvl);
    #5 cs_n <= lvl;
    #20;
  endtask : select

  // n bits MSB first; clock stands still outside transfers; frames run back to back
  // so every conversion ends far inside its droop limit
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx,
    output logic [31:0] sb);
    rx = '0;
    sb = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din <= tx[i];
      #4;
      // A released line reads as the inverse of its last level, never a clean zero
      last_dout = dout_oe_n ? ~last_dout : dout_o;
      rx = {rx[30:0], last_dout};
      sb = {sb[30:0], conversion_strobe_o};
      sclk <= 1'b1;
      #7.5 sclk <= 1'b0;
      #3.5;
    end
    din <= 1'b0;
    #1;
  endtask : xfer
endmodule : adc_host_model

/* File: dv/tb_top.sv */
// Self-checking bench for the serial converter control block
`timescale 1ns/10ps
module tb_top;
  logic clk;
  logic rst;
  logic hard_shutdown_n;
  logic [7:0] analog_value;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe_n;
  logic conversion_strobe_o;
  logic conversion_strobe_oe_n;
  logic powered_up;
  logic conversion_active;
  logic [2:0] channel_select;
  logic polarity_select;
  logic input_config_select;
  int n_errors;
  int tests_run;

  adc_serial_conversion_control dut_u (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout_o(dout_o),
    .dout_oe_n(dout_oe_n),
    .conversion_strobe_o(conversion_strobe_o),
    .conversion_strobe_oe_n(conversion_strobe_oe_n),
    .hard_shutdown_n(hard_shutdown_n),
    .analog_value(analog_value),
    .powered_up(powered_up),
    .conversion_active(conversion_active),
    .channel_select(channel_select),
    .polarity_select(polarity_select),
    .input_config_select(input_config_select)
  );

  adc_host_model host_u (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .dout_o(dout_o),
    .dout_oe_n(dout_oe_n),
    .conversion_strobe_o(conversion_strobe_o)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait on the strobe, counting system clocks
  task automatic wait_strobe(input logic lvl, output int n);
    n = 0;
    while (conversion_strobe_o !== lvl)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400)
      begin
        n_errors++;
        $display("ERROR at %0t: strobe %h expected %h", $time, conversion_strobe_o, lvl);
        give_verdict();
      end
    end
  endtask : wait_strobe

  task automatic t_reset();
    logic [31:0] rx;
    logic [31:0] sb;
    chk(32'({conversion_strobe_o, conversion_strobe_oe_n}), 32'h2);
    chk(32'({powered_up, conversion_active}), 32'h2);
    chk(32'({channel_select, polarity_select, input_config_select}), 32'h0);
    host_u.select(1'b0);
    host_u.xfer(32'h0, 8, rx, sb);
    chk(32'(rx[7:0]), 32'h0);
    host_u.select(1'b1);
    $display("done: reset");
  endtask : t_reset

  task automatic t_ext();
    logic [31:0] rx;
    logic [31:0] sb;
    @(posedge clk);
    analog_value <= 8'hA5;
    host_u.select(1'b0);
    // Leading zero byte before the control byte
    host_u.xfer({8'h00, 8'hDB, 16'h0000}, 32, rx, sb);
    chk(32'(rx[15:0]), 32'({2'b00, 8'hA5, 6'h00}));
    chk(32'(sb[15:8]), 32'hC0);
    // Configuration crosses into the system clock after the byte
    repeat (4) @(posedge clk);
    #1;
    chk(32'({channel_select, polarity_select, input_config_select}), 32'h16);
    host_u.select(1'b1);
    chk(32'({dout_oe_n, conversion_strobe_oe_n}), 32'h3);
    host_u.select(1'b0);
    chk(32'({conversion_strobe_oe_n, conversion_strobe_o}), 32'h0);
    host_u.select(1'b1);
    $display("done: ext");
  endtask : t_ext

  task automatic t_overlap();
    logic [31:0] rx;
    logic [31:0] sb;
    @(posedge clk);
    analog_value <= 8'h5A;
    host_u.select(1'b0);
    host_u.xfer(32'({8'hFF, 2'b00, 8'hFF, 2'b00, 10'h000}), 30, rx, sb);
    chk(32'(rx[19:12]), 32'h5A);
    chk(32'(rx[11:10]), 32'h0);
    chk(32'(rx[9:2]), 32'h5A);
    host_u.select(1'b1);
    $display("done: overlap");
  endtask : t_overlap

  // Internal pacing; the link clock is held low while converting
  task automatic int_run(input logic [7:0] c, input logic [7:0] v, input bit mid_cs);
    logic [31:0] rx;
    logic [31:0] sb;
    int n;
    @(posedge clk);
    analog_value <= v;
    host_u.select(1'b0);
    host_u.xfer(32'(c), 8, rx, sb);
    wait_strobe(1'b0, n);
    chk(32'(n < 8), 32'h1);
    chk(32'(conversion_active), 32'h1);
    if (mid_cs)
    begin
      host_u.select(1'b1);
      chk(32'({conversion_strobe_oe_n, dout_oe_n}), 32'h1);
      host_u.select(1'b0);
    end
    wait_strobe(1'b1, n);
    chk(32'(n >= adc_ctrl_pkg::CONV_CYCLES - 3), 32'h1);
    chk(32'(n <= adc_ctrl_pkg::CONV_CYCLES + 3), 32'h1);
    repeat (5) @(posedge clk);
    #1;
    chk(32'(powered_up), 32'(c[1]));
    host_u.xfer(32'h0, 16, rx, sb);
    chk(32'(rx[13:6]), 32'(v));
    chk(32'(rx[5:0]), 32'h0);
    host_u.select(1'b1);
  endtask : int_run

  task automatic t_shutdown();
    logic [31:0] rx;
    logic [31:0] sb;
    int n;
    host_u.select(1'b0);
    host_u.xfer(32'h8E, 8, rx, sb);
    wait_strobe(1'b0, n);
    chk(32'(powered_up), 32'h1);
    @(posedge clk);
    hard_shutdown_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(32'({conversion_active, powered_up}), 32'h0);
    hard_shutdown_n <= 1'b1;
    repeat (4) @(posedge clk);
    host_u.select(1'b1);
    $display("done: shutdown");
  endtask : t_shutdown

  // Reset in mid-run; the link clock must run while it is held
  task automatic t_mid_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    host_u.idle_clocks(8);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'({conversion_strobe_o, conversion_active}), 32'h2);
    @(posedge clk);
    #1;
    chk(32'({conversion_strobe_o, conversion_active}), 32'h2);
    host_u.idle_clocks(6);
    t_reset();
  endtask : t_mid_reset

  // Select toggled during a serial-paced strobe, then a fresh byte
  task automatic t_abort();
    logic [31:0] rx;
    logic [31:0] sb;
    @(posedge clk);
    analog_value <= 8'hFF;
    host_u.select(1'b0);
    host_u.xfer(32'h11E, 9, rx, sb);
    chk(32'(sb[0]), 32'h1);
    host_u.select(1'b1);
    @(posedge clk);
    analog_value <= 8'h96;
    host_u.select(1'b0);
    chk(32'({conversion_strobe_oe_n, conversion_strobe_o}), 32'h0);
    host_u.xfer(32'({4'h0, 8'h8F, 2'b00, 8'h00}), 22, rx, sb);
    chk(32'(rx[20:8]), 32'h0);
    chk(32'(rx[7:0]), 32'h96);
    chk(32'(sb[9:8]), 32'h3);
    host_u.select(1'b1);
    $display("done: abort");
  endtask : t_abort

  initial
  begin
    rst = 1'b1;
    hard_shutdown_n = 1'b1;
    analog_value = 8'h00;
    n_errors = 0;
    tests_run = 0;
    // The link domain needs clock edges to see reset
    fork
      host_u.idle_clocks(60);
    join_none
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #300;
    host_u.idle_clocks(6);
    t_reset();
    t_ext();
    t_overlap();
    int_run(8'h8E, 8'h3C, 1'b1);
    $display("done: internal");
    int_run(8'h8C, 8'hC3, 1'b0);
    $display("done: power-down");
    t_shutdown();
    t_mid_reset();
    t_abort();
    give_verdict();
  end
endmodule : tb_top
